// ===== serial_frame_control.v
// frame control, transmit and receive framing, pin routing and interrupts
// Notes on behaviour
// [R1] loop select joins transmitter to receiver internally
// [R2] freeze bit stops port clocks during wait
// [R3] receiver source ignored while loop clear
// [R4] loop: source 0 internal, 1 single wire
// [R5] start, 8 data lsb first, optional ninth, stop
// [R6] wakeup bit picks idle line or address mark
// [R7] idle count starts after start or stop
// [R8] parity enable makes msb the parity bit
// [R9] parity type zero even, one odd
// [R10] buffer empty flag with enable requests interrupt
// [R11] transmit idle flag with enable requests interrupt
// [R12] receive full flag with enable requests interrupt
// [R13] idle line flag with enable requests interrupt
// [R14] transmitter runs and owns pin when on
// [R15] single wire direction bit steers shared pin
// [R16] off then on while busy queues idle
// [R17] pin held until pending data, idle, break done
// [R18] receive pin released when off or looped
// [R19] control registers reset to zero
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "serial_frame_control_defs.vh"
module serial_frame_control #(
  parameter OS_DIV = 163
) (
  input wire clk,
  input wire rst,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire wait_mode,
  input wire tx_buf_empty_flag,
  input wire tx_idle_flag,
  input wire rx_buf_full_flag,
  input wire idle_line_flag,
  input wire [8:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  output reg [8:0] rx_data,
  output reg rx_valid,
  output reg rx_parity_err,
  output reg idle_detect,
  output wire wake_by_addr,
  output wire rx_enabled,
  output wire clocks_frozen,
  output wire tx_irq_req,
  output wire rx_irq_req,
  output wire irq,
  input wire tx_pin_in,
  output wire tx_pin_out,
  output wire tx_pin_oe,
  input wire rx_pin_in,
  output wire rx_pin_owned
);
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;
  localparam RX_STOP = 2'b11;

  reg [7:0] ctrl_one_reg;
  reg [7:0] ctrl_two_reg;
  reg [`AUX_W-1:0] aux_reg;
  reg [`IRQ_W-1:0] status_reg;
  reg [`IRQ_W-1:0] status_next;
  reg [`IRQ_W-1:0] mask_reg;
  reg [`IRQ_W-1:0] src_prev_reg;
  reg tx_on_prev_reg;
  reg sbk_prev_reg;
  reg idle_q_reg;
  reg brk_q_reg;
  reg [1:0] tx_pin_sync_reg;
  reg [1:0] rx_pin_sync_reg;
  reg [1:0] rx_state_reg;
  reg [3:0] rx_os_reg;
  reg [3:0] rx_bit_reg;
  reg [8:0] rx_sh_reg;
  reg [3:0] idle_cnt_reg;
  reg idle_armed_reg;
  reg [`FRAME_W-1:0] pattern;
  reg [3:0] pat_len;
  reg tx_par;
  reg [8:0] rx_word;
  wire os_tick;
  wire tx_line;
  wire tx_busy;
  wire load;
  wire start_idle;
  wire start_brk;
  wire start_data;
  wire rx_line;
  wire bit_sample;
  wire [3:0] data_last;
  wire [3:0] idle_len;
  wire [`IRQ_W-1:0] src_now;
  wire [`IRQ_W-1:0] src_rise;

  // field aliases
  wire loopback_sel = ctrl_one_reg[`B_LOOP];
  wire freeze_in_wait = ctrl_one_reg[`B_FREEZE];
  wire rx_source_sel = ctrl_one_reg[`B_RX_SOURCE_SEL];
  wire nine_bit = ctrl_one_reg[`B_NINE];
  wire idle_count_after_stop = ctrl_one_reg[`B_ILT];
  wire parity_enable = ctrl_one_reg[`B_PE];
  wire odd_parity_sel = ctrl_one_reg[`B_PT];
  wire tx_empty_irq_en = ctrl_two_reg[`B_TIE];
  wire tx_done_irq_en = ctrl_two_reg[`B_TX_DONE_IRQ_EN];
  wire rx_full_irq_en = ctrl_two_reg[`B_RIE];
  wire idle_irq_en = ctrl_two_reg[`B_IDLE_IRQ_EN];
  wire tx_on = ctrl_two_reg[`B_TE];
  wire rx_on = ctrl_two_reg[`B_RE];
  wire single_wire_dir = aux_reg[`B_DIR];
  wire send_break = aux_reg[`B_SBK];
  wire single_wire = loopback_sel & rx_source_sel;

  // register address match
  function sel;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // control registers, writable any time
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_one_reg <= `CTRL_RST; // [R19]
      ctrl_two_reg <= `CTRL_RST; // [R19]
      aux_reg <= 2'h0;
      mask_reg <= `IRQ_RST;
    end else if (reg_wr) begin
      if (sel(reg_addr, `OFS_CTRL_ONE))
        ctrl_one_reg <= reg_wdata;
      if (sel(reg_addr, `OFS_CTRL_TWO))
        ctrl_two_reg <= reg_wdata;
      if (sel(reg_addr, `OFS_AUX_CTRL))
        aux_reg <= reg_wdata[`AUX_W-1:0];
      if (sel(reg_addr, `OFS_IRQ_MASK))
        mask_reg <= reg_wdata[`IRQ_W-1:0];
    end
  end

  // read data in the cycle after the read strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_CTRL_ONE: reg_rdata <= ctrl_one_reg;
        `OFS_CTRL_TWO: reg_rdata <= ctrl_two_reg;
        `OFS_IRQ_STATUS: reg_rdata <= {3'h0, status_reg};
        `OFS_IRQ_MASK: reg_rdata <= {3'h0, mask_reg};
        `OFS_AUX_CTRL: reg_rdata <= {6'h00, aux_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // sticky event bits, a new event wins over a write-one clear
  assign src_now = {rx_parity_err, idle_line_flag, rx_buf_full_flag,
                    tx_idle_flag, tx_buf_empty_flag};
  assign src_rise = src_now & ~src_prev_reg;
  always @* begin
    status_next = status_reg;
    if (reg_wr && sel(reg_addr, `OFS_IRQ_STATUS))
      status_next = status_next & ~reg_wdata[`IRQ_W-1:0];
    status_next = status_next | src_rise;
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= `IRQ_RST;
      src_prev_reg <= `IRQ_RST;
    end else begin
      status_reg <= status_next;
      src_prev_reg <= src_now;
    end
  end
  assign irq = |(status_reg & mask_reg);

  // level requests from the status flags
  assign tx_irq_req = (tx_buf_empty_flag & tx_empty_irq_en) | // [R10]
                      (tx_idle_flag & tx_done_irq_en); // [R11]
  assign rx_irq_req = (rx_buf_full_flag & rx_full_irq_en) | // [R12]
                      (idle_line_flag & idle_irq_en); // [R13]

  // wait-mode freeze gates the oversample clock enable
  assign clocks_frozen = freeze_in_wait & wait_mode; // [R2]
  assign wake_by_addr = ctrl_one_reg[`B_WAKE]; // [R6]
  assign rx_enabled = rx_on;

  tick_divider #(
    .DIV(OS_DIV)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .en(~clocks_frozen),
    .tick(os_tick)
  );

  // queued idle on transmitter turn-on and queued break on break request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_on_prev_reg <= 1'b0;
      sbk_prev_reg <= 1'b0;
      idle_q_reg <= 1'b0;
      brk_q_reg <= 1'b0;
    end else begin
      tx_on_prev_reg <= tx_on;
      sbk_prev_reg <= send_break;
      if (tx_on && !tx_on_prev_reg)
        idle_q_reg <= 1'b1; // [R16]
      else if (start_idle)
        idle_q_reg <= 1'b0;
      if (send_break && !sbk_prev_reg)
        brk_q_reg <= 1'b1;
      else if (start_brk)
        brk_q_reg <= send_break; // more breaks while still requested
    end
  end

  // priority after the current character: idle, then break, then data
  assign start_idle = idle_q_reg & ~tx_busy;
  assign start_brk = brk_q_reg & ~idle_q_reg & ~tx_busy;
  assign tx_ready = tx_on & tx_on_prev_reg & ~tx_busy & ~idle_q_reg & ~brk_q_reg; // [R14]
  assign start_data = tx_valid & tx_ready;
  assign load = start_idle | start_brk | start_data;

  // parity replaces the most significant data bit
  always @* begin
    if (nine_bit)
      tx_par = (^tx_data[7:0]) ^ odd_parity_sel; // [R9]
    else
      tx_par = (^tx_data[6:0]) ^ odd_parity_sel; // [R9]
  end

  // build the character pattern, lsb first after the start bit
  always @* begin
    pat_len = nine_bit ? `FRAME_LEN_9 : `FRAME_LEN_8;
    pattern = 11'h7ff;
    if (start_idle) begin
      pattern = 11'h7ff;
    end else if (start_brk) begin
      pattern = 11'h000;
    end else if (nine_bit) begin
      pattern = {1'b1, parity_enable ? tx_par : tx_data[8],
                 tx_data[7:0], 1'b0}; // [R5] [R8]
    end else begin
      pattern = {2'b11, parity_enable ? tx_par : tx_data[7],
                 tx_data[6:0], 1'b0}; // [R5] [R8]
    end
  end

  tx_shifter u_tx (
    .clk(clk),
    .rst(rst),
    .os_tick(os_tick),
    .load(load),
    .pattern(pattern),
    .len(pat_len),
    .line(tx_line),
    .busy(tx_busy)
  );

  // pin ownership: held until all queued activity has gone out
  assign tx_pin_out = tx_line;
  assign tx_pin_oe = (tx_on | tx_busy | idle_q_reg | brk_q_reg) & // [R17]
                     (~single_wire | single_wire_dir); // [R15]
  assign rx_pin_owned = rx_on & ~loopback_sel; // [R18]

  // two-stage synchronisers for both pins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pin_sync_reg <= 2'b11;
      rx_pin_sync_reg <= 2'b11;
    end else begin
      tx_pin_sync_reg <= {tx_pin_sync_reg[0], tx_pin_in};
      rx_pin_sync_reg <= {rx_pin_sync_reg[0], rx_pin_in};
    end
  end

  // receiver input selection; source bit matters only when looped
  assign rx_line = !loopback_sel ? rx_pin_sync_reg[1] : // [R1] [R3]
                   rx_source_sel ? tx_pin_sync_reg[1] : // [R4]
                   tx_line; // [R4]

  assign data_last = nine_bit ? `DATA_LAST_9 : `DATA_LAST_8;
  assign idle_len = nine_bit ? `FRAME_LEN_9 : `FRAME_LEN_8; // [R7]
  assign bit_sample = os_tick & (rx_os_reg == `OS_MID);

  // received word with the received parity bit in its msb
  always @* begin
    if (nine_bit)
      rx_word = rx_sh_reg;
    else
      rx_word = {1'b0, rx_sh_reg[8:1]};
  end

  // receive state machine, sampling mid-bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_os_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_data <= 9'h000;
      rx_valid <= 1'b0;
      rx_parity_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_parity_err <= 1'b0;
      if (!rx_on) begin
        rx_state_reg <= RX_IDLE;
        rx_os_reg <= 4'h0;
      end else if (os_tick) begin
        rx_os_reg <= rx_os_reg + 4'h1;
        case (rx_state_reg)
          RX_IDLE: begin
            if (!rx_line) begin
              rx_state_reg <= RX_START;
              rx_os_reg <= 4'h1;
            end
          end
          RX_START: begin
            if (rx_os_reg == `OS_MID) begin
              rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
              rx_bit_reg <= 4'h0;
            end
          end
          RX_DATA: begin
            if (rx_os_reg == `OS_MID) begin
              rx_sh_reg <= {rx_line, rx_sh_reg[8:1]}; // [R5]
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == data_last)
                rx_state_reg <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_os_reg == `OS_MID) begin
              rx_state_reg <= RX_IDLE;
              rx_data <= rx_word;
              rx_valid <= 1'b1;
              rx_parity_err <= parity_enable & // [R8]
                               ((^rx_word) ^ odd_parity_sel); // [R9]
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // idle line count of high bit times, reported once per quiet period
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt_reg <= 4'h0;
      idle_armed_reg <= 1'b0;
      idle_detect <= 1'b0;
    end else begin
      idle_detect <= 1'b0;
      if (!rx_on) begin
        idle_cnt_reg <= 4'h0;
        idle_armed_reg <= 1'b0;
      end else if (bit_sample) begin
        if (rx_state_reg == RX_START) begin
          idle_cnt_reg <= 4'h0;
          idle_armed_reg <= 1'b1;
        end else if (!rx_line) begin
          idle_cnt_reg <= 4'h0;
        end else if (idle_count_after_stop && rx_state_reg != RX_IDLE) begin
          idle_cnt_reg <= 4'h0; // [R7]
        end else if (idle_cnt_reg != idle_len) begin
          idle_cnt_reg <= idle_cnt_reg + 4'h1; // [R7]
          if (idle_cnt_reg + 4'h1 == idle_len && idle_armed_reg) begin
            idle_detect <= 1'b1;
            idle_armed_reg <= 1'b0;
          end
        end
      end
    end
  end
endmodule // serial_frame_control

// ===== serial_frame_control_defs.vh
// constants for the serial frame control block
`ifndef SERIAL_FRAME_CONTROL_DEFS_VH
`define SERIAL_FRAME_CONTROL_DEFS_VH
// register offsets on the plain register port
`define ADDR_W 3
`define OFS_CTRL_ONE 3'h0
`define OFS_CTRL_TWO 3'h1
`define OFS_IRQ_STATUS 3'h2
`define OFS_IRQ_MASK 3'h3
`define OFS_AUX_CTRL 3'h4
`define CTRL_RST 8'h00
`define IRQ_W 5
`define IRQ_RST 5'h00
// first control register fields
`define B_LOOP 7
`define B_FREEZE 6
`define B_RX_SOURCE_SEL 5
`define B_NINE 4
`define B_WAKE 3
`define B_ILT 2
`define B_PE 1
`define B_PT 0
// second control register fields
`define B_TIE 7
`define B_TX_DONE_IRQ_EN 6
`define B_RIE 5
`define B_IDLE_IRQ_EN 4
`define B_TE 3
`define B_RE 2
// auxiliary control fields
`define B_DIR 0
`define B_SBK 1
`define AUX_W 2
// status bit positions
`define S_TX_EMPTY 0
`define S_TX_IDLE 1
`define S_RX_FULL 2
`define S_IDLE 3
`define S_PAR_ERR 4
// bit timing in oversample ticks
`define OS_LAST 4'hf
`define OS_MID 4'h7
// frame lengths in bit times
`define FRAME_LEN_8 4'ha
`define FRAME_LEN_9 4'hb
`define DATA_LAST_8 4'h7
`define DATA_LAST_9 4'h8
`define FRAME_W 11
`endif

// ===== tick_divider.v
// oversample tick divider with enable
`timescale 1ns/1ps
module tick_divider #(
  parameter DIV = 163
) (
  input wire clk,
  input wire rst,
  input wire en,
  output reg tick
);
  localparam CW = 16;
  localparam [CW-1:0] LAST = DIV - 1;
  reg [CW-1:0] cnt_reg;

  // count bus clocks, pulse once per period, hold while disabled
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (!en) begin
      tick <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // tick_divider

// ===== tx_shifter.v
// transmit shifter for one character, idle or break, lsb first
`timescale 1ns/1ps
`include "serial_frame_control_defs.vh"
module tx_shifter (
  input wire clk,
  input wire rst,
  input wire os_tick,
  input wire load,
  input wire [`FRAME_W-1:0] pattern,
  input wire [3:0] len,
  output reg line,
  output reg busy
);
  reg [`FRAME_W-1:0] sh_reg;
  reg [3:0] left_reg;
  reg [3:0] os_reg;

  // shift one bit every sixteen oversample ticks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 11'h7ff;
      left_reg <= 4'h0;
      os_reg <= 4'h0;
      line <= 1'b1;
      busy <= 1'b0;
    end else if (load && !busy) begin
      sh_reg <= pattern;
      left_reg <= len;
      os_reg <= 4'h0;
      line <= pattern[0];
      busy <= 1'b1;
    end else if (busy && os_tick) begin
      os_reg <= os_reg + 4'h1;
      if (os_reg == `OS_LAST) begin
        sh_reg <= {1'b1, sh_reg[`FRAME_W-1:1]};
        left_reg <= left_reg - 4'h1;
        if (left_reg == 4'h1) begin
          busy <= 1'b0;
          line <= 1'b1; // mark level between characters
        end else begin
          line <= sh_reg[1];
        end
      end
    end
  end
endmodule // tx_shifter

// ===== serial_frame_control_asserts.sv
// checker for the serial frame control block
`timescale 1ns/1ps
`include "serial_frame_control_defs.vh"
module serial_frame_control_asserts (
  input wire clk,
  input wire rst,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire wait_mode,
  input wire tx_buf_empty_flag,
  input wire tx_idle_flag,
  input wire rx_buf_full_flag,
  input wire idle_line_flag,
  input wire tx_valid,
  input wire tx_ready,
  input wire rx_valid,
  input wire rx_parity_err,
  input wire wake_by_addr,
  input wire rx_enabled,
  input wire clocks_frozen,
  input wire tx_irq_req,
  input wire rx_irq_req,
  input wire irq,
  input wire tx_pin_out,
  input wire tx_pin_oe,
  input wire rx_pin_owned
);
  reg [7:0] c1_reg;
  reg [7:0] c2_reg;
  reg dir_reg;
  wire sw = c1_reg[7] & c1_reg[5];
  // mirror of the control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      c1_reg <= 8'h00;
      c2_reg <= 8'h00;
      dir_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_CTRL_ONE) c1_reg <= reg_wdata;
      if (reg_addr == `OFS_CTRL_TWO) c2_reg <= reg_wdata;
      if (reg_addr == `OFS_AUX_CTRL) dir_reg <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_tx_irq_map: assert property (tx_irq_req ==
    ((tx_buf_empty_flag & c2_reg[7]) | (tx_idle_flag & c2_reg[6]))) else $error("tx irq wrong");
  a_rx_irq_map: assert property (rx_irq_req ==
    ((rx_buf_full_flag & c2_reg[5]) | (idle_line_flag & c2_reg[4]))) else $error("rx irq wrong");
  a_freeze_map: assert property (clocks_frozen == (c1_reg[6] & wait_mode))
    else $error("freeze wrong");
  a_rx_pin_own: assert property (rx_pin_owned == (c2_reg[2] & ~c1_reg[7]))
    else $error("rx pin ownership wrong");
  a_wake_sel: assert property (wake_by_addr == c1_reg[3]) else $error("wake method wrong");
  a_rx_en_map: assert property (rx_enabled == c2_reg[2]) else $error("rx enable wrong");
  a_ctrl_readback: assert property (reg_rd && reg_addr == `OFS_CTRL_TWO |=>
    reg_rdata == c2_reg) else $error("ctrl two readback wrong");
  a_tx_start_bit: assert property (tx_valid && tx_ready |=> !tx_pin_out && !tx_ready)
    else $error("no start bit");
  a_tx_off_ready: assert property (!c2_reg[3] |-> !tx_ready) else $error("ready while off");
  a_tx_pin_own: assert property (c2_reg[3] && !sw |-> tx_pin_oe) else $error("pin not driven");
  a_sw_dir_off: assert property (sw && !dir_reg |-> !tx_pin_oe) else $error("pin driven");
  a_held_on_off: assert property (!tx_pin_out && (!sw || dir_reg) |-> tx_pin_oe)
    else $error("pin released early");
  c_tx_take: cover property (tx_valid && tx_ready);
  c_rx_perr: cover property (rx_valid && rx_parity_err);
  c_irq: cover property (irq);
endmodule // serial_frame_control_asserts
bind serial_frame_control serial_frame_control_asserts i_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wait_mode(wait_mode), .tx_buf_empty_flag(tx_buf_empty_flag),
  .tx_idle_flag(tx_idle_flag), .rx_buf_full_flag(rx_buf_full_flag),
  .idle_line_flag(idle_line_flag), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_valid(rx_valid), .rx_parity_err(rx_parity_err), .wake_by_addr(wake_by_addr),
  .clocks_frozen(clocks_frozen), .tx_irq_req(tx_irq_req), .rx_irq_req(rx_irq_req), .irq(irq),
  .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_owned(rx_pin_owned),
  .rx_enabled(rx_enabled));

// ===== remote_peer.sv
// remote serial peer: sends frames and captures frames seen on its line
`timescale 1ns/1ps
module remote_peer #(
  parameter BIT = 32
) (
  input wire clk,
  input wire line_in,
  input wire nine,
  output reg line_out,
  output reg [8:0] got,
  output reg [7:0] got_n
);
  integer i;
  integer j;
  reg [8:0] tmp;
  initial begin
    line_out = 1'b1;
    got = 9'h000;
    got_n = 8'h00;
  end
  // start, data lsb first, one stop bit
  task send(input [8:0] d, input integer n);
    begin
      line_out <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (i = 0; i < n; i = i + 1) begin
        line_out <= d[i];
        repeat (BIT) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (BIT) @(posedge clk);
    end
  endtask
  // mid-bit sampling after a falling edge
  always @(posedge clk) begin
    if (line_in === 1'b0) begin
      tmp = 9'h000;
      repeat (BIT / 2) @(posedge clk);
      for (j = 0; j < (nine ? 9 : 8); j = j + 1) begin
        repeat (BIT) @(posedge clk);
        tmp[j] = line_in;
      end
      repeat (BIT) @(posedge clk);
      got <= tmp;
      got_n <= got_n + 8'h01;
    end
  end
endmodule // remote_peer

// ===== testbench.sv
// self-checking bench for the serial frame control block
`timescale 1ns/1ps
`include "serial_frame_control_defs.vh"
module testbench;
  localparam OSD = 2;
  localparam BIT = 16 * OSD;
  reg clk, rst, reg_wr, reg_rd, wait_mode, tx_valid, nine, e;
  reg [2:0] reg_addr;
  reg [7:0] reg_wdata, v, r;
  reg [3:0] flg;
  reg [8:0] tx_data, d, w, g;
  reg [2:0] c;
  reg [2:0] cfg [0:4];
  integer seed, n_errors, compares, m, k;
  wire [7:0] reg_rdata, got_n;
  wire [8:0] rx_data, got;
  wire tx_ready, rx_valid, rx_parity_err, irq, clocks_frozen, tx_pin_out, tx_pin_oe, peer_out;
  wire idle_detect;
  wire tx_line = tx_pin_oe ? tx_pin_out : 1'b1;
  serial_frame_control #(.OS_DIV(OSD)) i_serial_frame_control (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wait_mode(wait_mode), .tx_buf_empty_flag(flg[0]),
    .tx_idle_flag(flg[1]), .rx_buf_full_flag(flg[2]), .idle_line_flag(flg[3]),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_parity_err(rx_parity_err), .idle_detect(idle_detect),
    .wake_by_addr(),
    .rx_enabled(), .clocks_frozen(clocks_frozen), .tx_irq_req(), .rx_irq_req(), .irq(irq),
    .tx_pin_in(tx_line), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .rx_pin_in(peer_out), .rx_pin_owned());
  remote_peer #(.BIT(BIT)) i_remote_peer (.clk(clk), .line_in(tx_line), .nine(nine),
    .line_out(peer_out), .got(got), .got_n(got_n));
  // expected data bits: msb replaced by parity when enabled
  function [8:0] exp_word(input [8:0] x, input [2:0] cf);
    begin
      exp_word = cf[2] ? x : {1'b0, x[7:0]};
      if (cf[1] && cf[2]) exp_word[8] = ^x[7:0] ^ cf[0];
      if (cf[1] && !cf[2]) exp_word[7] = ^x[6:0] ^ cf[0];
    end
  endfunction
  task report_and_stop;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [8:0] ex, input [8:0] sn);
    begin
      compares = compares + 1;
      if (sn !== ex) begin
        n_errors = n_errors + 1;
        $display("Error %0s expected %h seen %h", nm, ex, sn);
      end
    end
  endtask
  task hang(input [63:0] nm);
    begin
      n_errors = n_errors + 1;
      $display("Error %0s timed out", nm);
      report_and_stop;
    end
  endtask
  task wr(input [2:0] a, input [7:0] x);
    begin
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [2:0] a, output [7:0] x);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      x = reg_rdata;
      @(posedge clk);
    end
  endtask
  task tx_send(input [8:0] x);
    integer i;
    begin
      tx_data <= x;
      tx_valid <= 1'b1;
      i = 0;
      do begin @(negedge clk); i = i + 1; end while (tx_ready !== 1'b1 && i < 40 * BIT);
      if (tx_ready !== 1'b1) hang("tx_ready");
      @(posedge clk);
      tx_valid <= 1'b0;
    end
  endtask
  task wait_rx(output [8:0] x, output pe);
    integer i;
    begin
      i = 0;
      do begin @(negedge clk); i = i + 1; end while (rx_valid !== 1'b1 && i < 40 * BIT);
      if (rx_valid !== 1'b1) hang("rx_valid");
      x = rx_data;
      pe = rx_parity_err;
      @(posedge clk);
    end
  endtask
  task wait_peer(input integer n0);
    integer i;
    begin
      i = 0;
      do begin @(negedge clk); i = i + 1; end while (got_n == n0 && i < 40 * BIT);
      if (got_n == n0) hang("peer");
      @(posedge clk);
    end
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // main sequence
  initial begin
    {rst, reg_wr, reg_rd, wait_mode, tx_valid, nine} = 6'b100000;
    {reg_addr, reg_wdata, flg, tx_data} = 24'h000000;
    {seed, n_errors, compares} = {32'd94, 32'd0, 32'd0};
    {cfg[0], cfg[1], cfg[2], cfg[3], cfg[4]} = {3'b000, 3'b010, 3'b011, 3'b100, 3'b111};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (m = 0; m < 8; m = m + 1) begin
      rd(m[2:0], r);
      chk("reset", 8'h00, r);
    end
    // random register traffic with random flag levels
    for (m = 0; m < 8; m = m + 1) begin
      v = $random(seed);
      flg <= $random(seed);
      wait_mode <= $random(seed);
      wr(`OFS_CTRL_ONE, v);
      rd(`OFS_CTRL_ONE, r);
      chk("ctrl_one", v, r);
      wr(`OFS_CTRL_TWO, v & 8'hf4);
      rd(`OFS_CTRL_TWO, r);
      chk("ctrl_two", v & 8'hf4, r);
    end
    wr(3'h5, 8'hff);
    rd(3'h5, r);
    chk("unmapped", 8'h00, r);
    // sticky status, mask, clear
    flg <= 4'h0;
    wait_mode <= 1'b0;
    wr(`OFS_IRQ_STATUS, 8'h1f);
    flg <= 4'h4;
    wr(`OFS_IRQ_MASK, 8'h04);
    rd(`OFS_IRQ_STATUS, r);
    chk("status", 8'h04, r);
    @(negedge clk) chk("irq_on", 1'b1, irq);
    @(posedge clk) wr(`OFS_IRQ_MASK, 8'h00);
    @(negedge clk) chk("irq_mask", 1'b0, irq);
    @(posedge clk) wr(`OFS_IRQ_MASK, 8'h04);
    wr(`OFS_IRQ_STATUS, 8'h04);
    @(negedge clk) chk("irq_clr", 1'b0, irq);
    // frame formats in both directions, receiver source set with loop clear
    for (m = 0; m < 5; m = m + 1) begin
      c = cfg[m];
      @(posedge clk) nine <= c[2];
      wr(`OFS_CTRL_ONE, {2'h0, 1'b1, c[2], 1'b0, c[0], c[1:0]});
      wr(`OFS_CTRL_TWO, 8'h0c);
      d = $random(seed);
      k = got_n;
      tx_send(d);
      wait_peer(k);
      chk("tx_word", exp_word(d, c), got);
      w = exp_word($random(seed), c);
      fork i_remote_peer.send(w, c[2] ? 9 : 8); wait_rx(g, e); join
      chk("rx_word", w, g);
      chk("rx_perr", 1'b0, e);
      fork i_remote_peer.send(w ^ 9'h001, c[2] ? 9 : 8); wait_rx(g, e); join
      chk("rx_perr", c[1], e);
      k = 0;
      do begin @(negedge clk); k = k + 1; end while (idle_detect !== 1'b1 && k < 40 * BIT);
      if (idle_detect !== 1'b1) hang("idle_det");
      chk("idle_det", 1'b1, idle_detect);
      @(posedge clk) wr(`OFS_CTRL_TWO, 8'h00);
    end
    // internal loopback while the receive pin carries other traffic
    nine <= 1'b0;
    wr(`OFS_CTRL_ONE, 8'h80);
    wr(`OFS_CTRL_TWO, 8'h0c);
    d = $random(seed);
    fork tx_send(d); i_remote_peer.send(9'h000, 8); wait_rx(g, e); join
    chk("loop_rx", {1'b0, d[7:0]}, g);
    // single wire direction
    wr(`OFS_CTRL_ONE, 8'ha0);
    wr(`OFS_AUX_CTRL, 8'h00);
    @(negedge clk) chk("sw_in", 1'b0, tx_pin_oe);
    @(posedge clk) wr(`OFS_AUX_CTRL, 8'h01);
    @(negedge clk) chk("sw_out", 1'b1, tx_pin_oe);
    // freeze in wait
    @(posedge clk) wr(`OFS_CTRL_ONE, 8'h40);
    wait_mode <= 1'b1;
    @(negedge clk) chk("frozen", 1'b1, clocks_frozen);
    @(posedge clk) wait_mode <= 1'b0;
    // transmitter off then on in mid-frame
    wr(`OFS_CTRL_ONE, 8'h00);
    wr(`OFS_CTRL_TWO, 8'h00);
    wr(`OFS_CTRL_TWO, 8'h08);
    tx_send(9'h0a5);
    repeat (3 * BIT) @(posedge clk);
    wr(`OFS_CTRL_TWO, 8'h00);
    @(negedge clk) chk("pin_held", 1'b1, tx_pin_oe);
    @(posedge clk) wr(`OFS_CTRL_TWO, 8'h08);
    k = 0;
    do begin @(negedge clk); k = k + 1; end while (tx_ready !== 1'b1 && k < 40 * BIT);
    if (tx_ready !== 1'b1) hang("idle_q");
    chk("idle_q", 1'b1, k > 12 * BIT);
    report_and_stop;
  end
endmodule // testbench
